// *** sdp_regs.vh ***
`ifndef SDP_REGS_VH
`define SDP_REGS_VH

// register byte addresses
`define SDP_ADDR_CTRL       8'h00
`define SDP_ADDR_PKT_LEN    8'h04
`define SDP_ADDR_DELIM      8'h08
`define SDP_ADDR_FORCE      8'h0c
`define SDP_ADDR_TCP_PORT   8'h10
`define SDP_ADDR_STATUS     8'h14
`define SDP_ADDR_FRAMES     8'h18

// control fields
`define SDP_CTRL_D1_EN      0
`define SDP_CTRL_D2_EN      1
`define SDP_CTRL_MODE_LO    2
`define SDP_CTRL_MODE_HI    3

// delimiter process modes
`define SDP_MODE_NONE       2'h0
`define SDP_MODE_PLUS1      2'h1
`define SDP_MODE_PLUS2      2'h2
`define SDP_MODE_STRIP      2'h3

// delimiter register fields
`define SDP_DELIM1_LO       0
`define SDP_DELIM2_LO       8

// status fields
`define SDP_ST_OPEN_LO      0
`define SDP_ST_USED_LO      12
`define SDP_ST_BUSY         24
`define SDP_ST_OVERRUN      25

// reset values
`define SDP_RST_CTRL        4'h0
`define SDP_RST_PKT_LEN     11'h000
`define SDP_RST_DELIM1      8'h00
`define SDP_RST_DELIM2      8'h00
`define SDP_RST_FORCE       16'h0000
`define SDP_RST_TCP_PORT    16'h0fa1

// buffer size in bytes
`define SDP_BUF_BYTES       11'h400

// timing: force-transmit unit and clock period
`define SDP_FT_UNIT_NS      1000000
`define SDP_CLK_PERIOD_NS   20

`endif

// *** sdp_fto.v ***
`timescale 1ns/1ps
`default_nettype none

// force-transmit timeout: millisecond prescaler plus idle counter
module sdp_fto #(
    parameter integer CYC_PER_MS = 50000
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // control
    input  wire [15:0] limit_i,
    input  wire        byte_i,
    input  wire        armed_i,
    // event
    output reg         expire_o
);

    reg  [31:0] pre;
    reg  [15:0] ms;
    wire        tick;

    assign tick = (pre == CYC_PER_MS - 1);

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre      <= 32'h0;
            ms       <= 16'h0;
            expire_o <= 1'b0;
        end else begin
            expire_o <= 1'b0;
            if (byte_i || limit_i == 16'h0 || !armed_i) begin
                // restart on every byte and while idle or disabled
                pre <= 32'h0; // RQ18 RQ11
                ms  <= 16'h0;
            end else if (tick) begin
                pre <= 32'h0;
                if (ms + 16'h1 == limit_i) begin
                    expire_o <= 1'b1; // RQ12 RQ18
                    ms       <= 16'h0;
                end else begin
                    ms <= ms + 16'h1;
                end
            end else begin
                pre <= pre + 32'h1;
            end
        end
    end

endmodule

`default_nettype wire

// *** sdp_packer.v ***
// Summary of operation
// [RQ1] nonzero length: flush when count equals length
// [RQ2] length zero disables length flush
// [RQ3] first delimiter match flushes, per process mode
// [RQ4] second delimiter also matches when both enabled
// [RQ5] second disabled: only first delimiter matches
// [RQ6] software must enable first delimiter
// [RQ7] full 1 KB buffer flushes on its own
// [RQ8] plus-one/plus-two wait for trailing bytes
// [RQ9] strip mode drops delimiter, flushes rest
// [RQ10] no-action mode flushes at the delimiter
// [RQ11] force timeout zero disables timeout
// [RQ12] bytes within timeout share one frame
// [RQ13] every byte buffered; send on full/timeout
// [RQ14] one 1 Kbyte receive buffer per port
// [RQ15] timeout above one character and 10 ms
// [RQ16] sender keeps gaps below timeout
// [RQ17] listen port register, default 4001
// [RQ18] timer restarts per byte, needs data
// [RQ19] coinciding triggers give one frame, clear
`timescale 1ns/1ps
`default_nettype none
`include "sdp_regs.vh"

module sdp_packer #(
    parameter integer CYC_PER_MS = `SDP_FT_UNIT_NS / `SDP_CLK_PERIOD_NS
) (
    // clock and reset
    input  wire        REF_CLK_I,
    input  wire        RST_I,
    // register port
    input  wire [7:0]  ADDR_I,
    input  wire [31:0] WDATA_I,
    input  wire        WR_I,
    input  wire        RD_I,
    output reg  [31:0] RDATA_O,
    // serial byte input
    input  wire [7:0]  RX_DATA_I,
    input  wire        RX_VALID_I,
    output wire        RX_READY_O,
    // network frame output
    output reg  [7:0]  TX_DATA_O,
    output reg         TX_VALID_O,
    output reg         TX_LAST_O,
    input  wire        TX_READY_I,
    // listen port for the link layer
    output wire [15:0] TCP_PORT_O
);

    localparam ST_IDLE  = 1'b0;
    localparam ST_DRAIN = 1'b1;

    // configuration
    reg  [3:0]  ctrl;
    reg  [10:0] pkt_len;
    reg  [7:0]  delim1;
    reg  [7:0]  delim2;
    reg  [15:0] force_ms;
    reg  [15:0] tcp_port;

    // buffer state
    reg  [7:0]  mem [0:1023]; // RQ14
    reg  [9:0]  wr_ptr;
    reg  [9:0]  rd_ptr;
    reg  [10:0] used;
    reg  [10:0] open_cnt;
    reg  [1:0]  post_left;
    reg         cls_valid;
    reg  [10:0] cls_len;
    reg  [10:0] drain_left;
    reg         state;
    reg         overrun;
    reg  [31:0] frames;

    wire [1:0]  mode;
    wire        d1_en;
    wire        d2_en;
    wire        acc;
    wire        hit;
    wire        strip_hit;
    wire        wr_en;
    wire        rd_en;
    wire [10:0] cnt_n;
    wire        len_hit;
    wire        full_hit;
    wire        now_hit;
    wire        post_hit;
    wire        to_hit;
    wire        close;
    wire        can_send;
    wire        fto_expire;

    // delimiter compare on one byte
    function dmatch;
        input [7:0] b;
        input [7:0] v1;
        input [7:0] v2;
        input       e1;
        input       e2;
        begin
            // second value only counts beside the first
            dmatch = e1 && (b == v1 || (e2 && b == v2)); // RQ3 RQ4 RQ5 RQ6
        end
    endfunction

    // 11-bit step with a 1-bit increment
    function [10:0] inc11;
        input [10:0] v;
        input        s;
        begin
            inc11 = v + {10'h0, s};
        end
    endfunction

    assign mode  = ctrl[`SDP_CTRL_MODE_HI:`SDP_CTRL_MODE_LO];
    assign d1_en = ctrl[`SDP_CTRL_D1_EN];
    assign d2_en = ctrl[`SDP_CTRL_D2_EN];
    assign TCP_PORT_O = tcp_port; // RQ17

    // back-pressure toward the serial side while full
    assign RX_READY_O = (used != `SDP_BUF_BYTES);
    assign acc = RX_VALID_I && RX_READY_O; // RQ13

    assign hit = acc && post_left == 2'h0 &&
                 dmatch(RX_DATA_I, delim1, delim2, d1_en, d2_en);
    assign strip_hit = hit && mode == `SDP_MODE_STRIP; // RQ9
    assign wr_en = acc && !strip_hit;
    assign cnt_n = inc11(open_cnt, wr_en);

    assign len_hit  = wr_en && pkt_len != 11'h0 &&
                      cnt_n == pkt_len; // RQ1 RQ2
    assign full_hit = wr_en &&
                      inc11(used, 1'b1) - {10'h0, rd_en} ==
                      `SDP_BUF_BYTES; // RQ7
    assign now_hit  = hit && (mode == `SDP_MODE_NONE ||
                              mode == `SDP_MODE_STRIP); // RQ10 RQ9
    assign post_hit = wr_en && post_left == 2'h1; // RQ8
    assign to_hit   = !acc && open_cnt != 11'h0 &&
                      fto_expire; // RQ13 RQ18

    // any trigger on a nonempty frame closes exactly one frame
    assign close = (len_hit || full_hit || now_hit || post_hit ||
                    to_hit) && cnt_n != 11'h0; // RQ19

    assign can_send = !TX_VALID_O || TX_READY_I;
    assign rd_en = state == ST_DRAIN && can_send &&
                   drain_left != 11'h0;

    sdp_fto #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_fto (
        .clk_i    (REF_CLK_I),
        .rst_i    (RST_I),
        .limit_i  (force_ms),
        .byte_i   (acc),
        .armed_i  (open_cnt != 11'h0),
        .expire_o (fto_expire)
    );

    // register writes
    always @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ctrl     <= `SDP_RST_CTRL;
            pkt_len  <= `SDP_RST_PKT_LEN;
            delim1   <= `SDP_RST_DELIM1;
            delim2   <= `SDP_RST_DELIM2;
            force_ms <= `SDP_RST_FORCE;
            tcp_port <= `SDP_RST_TCP_PORT;
        end else if (WR_I) begin
            if (ADDR_I == `SDP_ADDR_CTRL) begin
                ctrl <= WDATA_I[3:0];
            end else if (ADDR_I == `SDP_ADDR_PKT_LEN) begin
                pkt_len <= WDATA_I[10:0];
            end else if (ADDR_I == `SDP_ADDR_DELIM) begin
                delim1 <= WDATA_I[`SDP_DELIM1_LO +: 8];
                delim2 <= WDATA_I[`SDP_DELIM2_LO +: 8];
            end else if (ADDR_I == `SDP_ADDR_FORCE) begin
                force_ms <= WDATA_I[15:0];
            end else if (ADDR_I == `SDP_ADDR_TCP_PORT) begin
                tcp_port <= WDATA_I[15:0];
            end
        end
    end

    // register reads, data one cycle after the strobe
    always @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            RDATA_O <= 32'h0;
        end else if (!RD_I) begin
            RDATA_O <= 32'h0;
        end else if (ADDR_I == `SDP_ADDR_CTRL) begin
            RDATA_O <= {28'h0, ctrl};
        end else if (ADDR_I == `SDP_ADDR_PKT_LEN) begin
            RDATA_O <= {21'h0, pkt_len};
        end else if (ADDR_I == `SDP_ADDR_DELIM) begin
            RDATA_O <= {16'h0, delim2, delim1};
        end else if (ADDR_I == `SDP_ADDR_FORCE) begin
            RDATA_O <= {16'h0, force_ms};
        end else if (ADDR_I == `SDP_ADDR_TCP_PORT) begin
            RDATA_O <= {16'h0, tcp_port};
        end else if (ADDR_I == `SDP_ADDR_STATUS) begin
            RDATA_O <= {6'h0, overrun, state, 1'b0, used,
                        1'b0, open_cnt};
        end else if (ADDR_I == `SDP_ADDR_FRAMES) begin
            RDATA_O <= frames;
        end else begin
            RDATA_O <= 32'h0;
        end
    end

    // buffer write side
    always @(posedge REF_CLK_I) begin
        if (wr_en) begin
            mem[wr_ptr] <= RX_DATA_I; // RQ13
        end
    end

    // open frame, post-delimiter count, overrun flag
    always @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            wr_ptr    <= 10'h0;
            open_cnt  <= 11'h0;
            post_left <= 2'h0;
            overrun   <= 1'b0;
        end else begin
            if (wr_en) begin
                wr_ptr <= wr_ptr + 10'h1;
            end
            if (close) begin
                open_cnt  <= 11'h0; // RQ19
                post_left <= 2'h0;
            end else begin
                open_cnt <= cnt_n;
                if (hit && mode == `SDP_MODE_PLUS1) begin
                    post_left <= 2'h1; // RQ8
                end else if (hit && mode == `SDP_MODE_PLUS2) begin
                    post_left <= 2'h2; // RQ8
                end else if (wr_en && post_left != 2'h0) begin
                    post_left <= post_left - 2'h1;
                end
            end
            // a new drop wins over a clear in the same cycle
            if (RX_VALID_I && !RX_READY_O) begin
                overrun <= 1'b1;
            end else if (WR_I && ADDR_I == `SDP_ADDR_STATUS &&
                         WDATA_I[`SDP_ST_OVERRUN]) begin
                overrun <= 1'b0;
            end
        end
    end

    // buffer fill level
    always @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            used <= 11'h0;
        end else begin
            used <= inc11(used, wr_en) - {10'h0, rd_en};
        end
    end

    // one closed frame may wait while another drains
    always @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cls_valid <= 1'b0;
            cls_len   <= 11'h0;
        end else begin
            if (close) begin
                cls_valid <= 1'b1;
                // a frame still waiting absorbs the new one
                if (cls_valid) begin
                    cls_len <= cls_len + cnt_n; // RQ19
                end else begin
                    cls_len <= cnt_n;
                end
            end else if (state == ST_IDLE && cls_valid) begin
                cls_valid <= 1'b0;
            end
        end
    end

    // drain toward the network
    always @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state      <= ST_IDLE;
            drain_left <= 11'h0;
            rd_ptr     <= 10'h0;
            TX_DATA_O  <= 8'h0;
            TX_VALID_O <= 1'b0;
            TX_LAST_O  <= 1'b0;
            frames     <= 32'h0;
        end else begin
            case (state)
            ST_IDLE: begin
                if (can_send) begin
                    TX_VALID_O <= 1'b0;
                    TX_LAST_O  <= 1'b0;
                end
                if (cls_valid && !close) begin
                    state      <= ST_DRAIN;
                    drain_left <= cls_len;
                end
            end
            default: begin
                if (rd_en) begin
                    TX_DATA_O  <= mem[rd_ptr];
                    TX_VALID_O <= 1'b1;
                    TX_LAST_O  <= (drain_left == 11'h1);
                    rd_ptr     <= rd_ptr + 10'h1;
                    drain_left <= drain_left - 11'h1;
                end else if (can_send) begin
                    TX_VALID_O <= 1'b0;
                    TX_LAST_O  <= 1'b0;
                    state      <= ST_IDLE;
                    frames     <= frames + 32'h1;
                end
            end
            endcase
        end
    end

endmodule

`default_nettype wire

// *** sdp_packer_checker.sv ***
`timescale 1ns/1ps
`default_nettype none

module sdp_packer_checker (
    // clock and reset
    input wire logic        REF_CLK_I,
    input wire logic        RST_I,
    // register port
    input wire logic        RD_I,
    input wire logic [31:0] RDATA_O,
    // serial and frame sides
    input wire logic        RX_READY_O,
    input wire logic [7:0]  TX_DATA_O,
    input wire logic        TX_VALID_O,
    input wire logic        TX_LAST_O,
    input wire logic        TX_READY_I,
    input wire logic [15:0] TCP_PORT_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);

    sequence s_take;
        TX_VALID_O && TX_READY_I;
    endsequence
    sequence s_take_last;
        s_take ##0 TX_LAST_O;
    endsequence
    sequence s_held;
        TX_VALID_O && $stable({TX_LAST_O, TX_DATA_O});
    endsequence

    a_tx_hold: assert property (TX_VALID_O && !TX_READY_I |=> s_held)
        else $error("frame byte changed before acceptance");
    a_last_valid: assert property (TX_LAST_O |-> TX_VALID_O)
        else $error("last flag without valid byte");
    a_frame_gap: assert property (s_take_last |=> !TX_VALID_O)
        else $error("no idle cycle after frame end");
    a_full_flush: assert property ($fell(RX_READY_O) |-> ##[2:1000] s_take)
        else $error("full buffer not sent");
    a_room_back: assert property (!RX_READY_O ##0 s_take |=> RX_READY_O)
        else $error("room not freed after byte left");
    a_port_reset: assert property ($fell(RST_I) |-> TCP_PORT_O == 16'h0fa1)
        else $error("listen port reset value wrong");
    a_idle_reset: assert property ($fell(RST_I) |-> !TX_VALID_O && RX_READY_O)
        else $error("outputs not idle after reset");
    a_rdata_idle: assert property (!RD_I |=> RDATA_O == 32'h0)
        else $error("read data outside read cycle");
endmodule

bind sdp_packer sdp_packer_checker u_chk (
    .REF_CLK_I(REF_CLK_I),
    .RST_I(RST_I),
    .RD_I(RD_I),
    .RDATA_O(RDATA_O),
    .RX_READY_O(RX_READY_O),
    .TX_DATA_O(TX_DATA_O),
    .TX_VALID_O(TX_VALID_O),
    .TX_LAST_O(TX_LAST_O),
    .TX_READY_I(TX_READY_I),
    .TCP_PORT_O(TCP_PORT_O)
);

`default_nettype wire

// *** sdp_serial_dev.sv ***
`timescale 1ns/1ps
`default_nettype none

module sdp_serial_dev (
    // clock
    input  wire logic       clk_i,
    // byte handshake
    input  wire logic       rx_ready_i,
    output var  logic [7:0] rx_data_o,
    output var  logic       rx_valid_o
);
    initial begin
        rx_data_o = 8'h00;
        rx_valid_o = 1'b0;
    end

    // idle line shows the inverse of the last byte
    task automatic send(input logic [7:0] b, input int gap);
        repeat (gap) @(posedge clk_i);
        @(negedge clk_i);
        while (!rx_ready_i) @(negedge clk_i);
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        rx_data_o <= b;
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_data_o <= ~b;
    endtask

    // offers a byte without looking at ready, to provoke a drop
    task automatic offer(input logic [7:0] b);
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        rx_data_o <= b;
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_data_o <= ~b;
    endtask
endmodule

`default_nettype wire

// *** tb_serial_data_packer.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module tb_serial_data_packer;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        rd_d = 1'b0;
    logic        tx_ready = 1'b0;
    wire  [31:0] rdata;
    wire  [7:0]  rx_data;
    wire         rx_valid;
    wire         rx_ready;
    wire  [7:0]  tx_data;
    wire         tx_valid;
    wire         tx_last;
    wire  [15:0] tcp_port;
    logic [31:0] exp_rd;
    logic [8:0]  tq[$];
    logic [31:0] rq[$];
    logic [8:0]  exp_tx;
    logic [7:0]  v0;
    logic [7:0]  v1;
    int          i;
    int          mismatches = 0;
    int          n_compared = 0;

    always #10 clk = ~clk;

    sdp_packer #(.CYC_PER_MS(10)) u_dut (
        .REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .RX_DATA_I(rx_data),
        .RX_VALID_I(rx_valid), .RX_READY_O(rx_ready), .TX_DATA_O(tx_data),
        .TX_VALID_O(tx_valid), .TX_LAST_O(tx_last), .TX_READY_I(tx_ready),
        .TCP_PORT_O(tcp_port)
    );

    sdp_serial_dev u_dev (
        .clk_i(clk), .rx_ready_i(rx_ready), .rx_data_o(rx_data),
        .rx_valid_o(rx_valid)
    );

    // network side stalls at random; results checked against the queues
    always @(posedge clk) begin
        tx_ready <= ($urandom % 4) != 0;
        rd_d <= rd;
        if (rd_d) begin
            exp_rd = rq.pop_front();
            `CHK(rdata, exp_rd)
        end
        if (tx_valid && tx_ready) begin
            exp_tx = (tq.size() != 0) ? tq.pop_front() : 9'h1xx;
            `CHK({tx_last, tx_data}, exp_tx)
        end
    end

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask

    task automatic snd(input logic [7:0] b, input bit e, input bit l,
                       input int gap);
        if (e)
            tq.push_back({l, b});
        u_dev.send(b, gap);
    endtask

    task automatic drain;
        int n;
        for (n = 0; n < 3000 && tq.size() != 0; n++) @(posedge clk);
        repeat (4) @(posedge clk);
        `CHK(tq.size(), 0)
    endtask

    // never a delimiter value
    function automatic logic [7:0] rb();
        return {1'b1, 7'($urandom)};
    endfunction

    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        final_report();
    end

    initial begin
        void'($urandom(17));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_reg(8'h10, 32'h00000fa1);
        rd_reg(8'h1c, 32'h0);
        rd_reg(8'h04, 32'h0);
        rd_reg(8'h0c, 32'h0);
        wr_reg(8'h04, 32'd4);
        for (i = 0; i < 4; i++) snd(rb(), 1, i == 3, 0);
        drain();
        wr_reg(8'h08, 32'h00000a0d);
        wr_reg(8'h04, 32'd2);
        wr_reg(8'h00, 32'h1);
        snd(rb(), 1, 0, 0);
        snd(8'h0d, 1, 1, 0);
        drain();
        wr_reg(8'h04, 32'd0);
        for (i = 0; i < 4; i++) begin
            wr_reg(8'h00, {28'h0, i[1:0], 2'b01});
            snd(rb(), 1, i == 3, 0);
            snd(8'h0d, i != 3, i == 0, 0);
            if (i == 1 || i == 2) snd(rb(), 1, i == 1, 0);
            if (i == 2) snd(rb(), 1, 1, 0);
            drain();
        end
        wr_reg(8'h00, 32'h3);
        snd(rb(), 1, 0, 0);
        snd(8'h0a, 1, 1, 0);
        drain();
        wr_reg(8'h00, 32'h1);
        snd(8'h0a, 1, 0, 0);
        snd(8'h0d, 1, 1, 0);
        drain();
        wr_reg(8'h00, 32'h0);
        v0 = rb();
        v1 = rb();
        snd(v0, 0, 0, 0);
        snd(v1, 0, 0, 0);
        repeat (300) @(posedge clk);
        rd_reg(8'h14, 32'h00002002);
        tq.push_back({1'b0, v0});
        tq.push_back({1'b0, v1});
        wr_reg(8'h0c, 32'd11);
        for (i = 0; i < 2; i++) snd(rb(), 1, i == 1, 60);
        drain();
        wr_reg(8'h0c, 32'd0);
        for (i = 0; i < 1024; i++) snd(rb(), 1, i == 1023, 0);
        u_dev.offer(rb());
        drain();
        rd_reg(8'h14, 32'h02000000);
        wr_reg(8'h14, 32'h02000000);
        rd_reg(8'h14, 32'h0);
        rd_reg(8'h18, 32'd10);
        wr_reg(8'h10, 32'h00001389);
        rd_reg(8'h10, 32'h00001389);
        `CHK(tcp_port, 16'h1389)
        repeat (3) @(posedge clk);
        final_report();
    end
endmodule

`default_nettype wire
